// ==== verilog/pri_pkg.sv ====
package pri_pkg;

    // Bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int IDX_W = 14;
    localparam int IDX_LSB = 2;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PATH_CTRL = 14'h1983;
    localparam logic [IDX_W-1:0] IDX_CTRL_CELL_LABEL = 14'h19c9;
    localparam logic [IDX_W-1:0] IDX_CTRL_UNEQ_TRACE = 14'h19ca;
    localparam logic [IDX_W-1:0] IDX_CTRL_POINTER_AIS = 14'h19cb;
    localparam logic [IDX_W-1:0] IDX_STATUS = 14'h19cc;

    // Reset values
    localparam logic [7:0] RST_PATH_CTRL = 8'h01;
    localparam logic [7:0] RST_CTRL = 8'h00;

    // Common layout of the three control bytes
    localparam int HI_CODE_MSB = 7;
    localparam int HI_CODE_LSB = 5;
    localparam int HI_EN_BIT = 4;
    localparam int LO_CODE_MSB = 3;
    localparam int LO_CODE_LSB = 1;
    localparam int LO_EN_BIT = 0;

    // Source select field in the path control byte
    localparam int SRC_SEL_MSB = 4;
    localparam int SRC_SEL_LSB = 3;
    localparam logic [1:0] SRC_SEL_AUTO = 2'h0;

    // Remote defect bits inside G1 (line bits 5..7, MSB is bit 1)
    localparam int G1_RDI_MSB = 3;
    localparam int G1_RDI_LSB = 1;

    localparam logic [2:0] RDI_NONE = 3'h0;
    localparam int DEFECT_N = 6;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== verilog/pri_path_rdi_auto_insertion.sv ====
`timescale 1ns/1ns

module pri_path_rdi_auto_insertion (
    input wire logic clk_sys, // 25 MHz system clock
    input wire logic rst_n, // Synchronous reset, active low
    // Defect flags from the receive path processor, same clock
    input wire logic def_unequipped, // Unequipped declared
    input wire logic def_pointer_loss, // Loss of pointer declared
    input wire logic def_path_alarm, // Path AIS declared
    input wire logic def_trace_mismatch, // Trace mismatch declared
    input wire logic def_cell_delineation, // Cell delineation lost
    input wire logic def_label_mismatch, // Payload label mismatch
    // Outbound byte stream
    input wire logic [7:0] tx_byte_in, // Outbound byte before insertion
    input wire logic tx_g1_slot, // Current byte is G1
    output logic [7:0] tx_byte_out_q, // Outbound byte after insertion
    output logic tx_g1_slot_out_q, // G1 marker aligned to output
    output logic [2:0] rdi_code_q, // Code currently selected
    // AXI4-Lite slave
    input wire logic [pri_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [pri_pkg::DATA_W-1:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [pri_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [pri_pkg::DATA_W-1:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);

    logic [7:0] path_ctrl_q;
    logic [7:0] ctrl_cell_label_q;
    logic [7:0] ctrl_uneq_trace_q;
    logic [7:0] ctrl_pointer_ais_q;

    logic aw_full_q;
    logic aw_full_d;
    logic [pri_pkg::IDX_W-1:0] aw_idx_q;
    logic w_full_q;
    logic w_full_d;
    logic [7:0] w_byte_q;
    logic w_lane0_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [pri_pkg::DATA_W-1:0] rdata_q;

    logic wr_fire;
    logic wr_hit;
    logic [pri_pkg::IDX_W-1:0] ar_idx;
    logic [pri_pkg::DATA_W-1:0] rd_value;
    logic rd_hit;
    logic [2:0] rdi_code_d;
    logic [pri_pkg::DEFECT_N-1:0] defects;
    logic auto_mode;

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // Write path: address and data latched independently, either order
    // Ready stays low while a word waits, so nothing overwrites it
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

    always_comb
    begin
        aw_full_d = aw_full_q;
        if (s_axi_awvalid && awready_q)
            aw_full_d = 1'b1;
        else if (wr_fire)
            aw_full_d = 1'b0;
        w_full_d = w_full_q;
        if (s_axi_wvalid && wready_q)
            w_full_d = 1'b1;
        else if (wr_fire)
            w_full_d = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_idx_q <= '0;
            w_byte_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= !aw_full_d;
            wready_q <= !w_full_d;
            if (s_axi_awvalid && awready_q)
                aw_idx_q <= s_axi_awaddr[pri_pkg::ADDR_W-1:pri_pkg::IDX_LSB];
            if (s_axi_wvalid && wready_q)
            begin
                w_byte_q <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
            end
        end
    end

    always_comb
    begin
        wr_hit = 1'b1;
        unique case (aw_idx_q)
            pri_pkg::IDX_PATH_CTRL,
            pri_pkg::IDX_CTRL_CELL_LABEL,
            pri_pkg::IDX_CTRL_UNEQ_TRACE,
            pri_pkg::IDX_CTRL_POINTER_AIS,
            pri_pkg::IDX_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= pri_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? pri_pkg::RESP_OKAY : pri_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    // Control bytes; only byte lane 0 carries data
    // Upper lanes are dropped since every writable register is one byte wide
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            path_ctrl_q <= pri_pkg::RST_PATH_CTRL;
            ctrl_cell_label_q <= pri_pkg::RST_CTRL;
            ctrl_uneq_trace_q <= pri_pkg::RST_CTRL;
            ctrl_pointer_ais_q <= pri_pkg::RST_CTRL;
        end
        else if (wr_fire && w_lane0_q)
        begin
            if (aw_idx_q == pri_pkg::IDX_PATH_CTRL)
                path_ctrl_q <= w_byte_q;
            if (aw_idx_q == pri_pkg::IDX_CTRL_CELL_LABEL)
                ctrl_cell_label_q <= w_byte_q;
            if (aw_idx_q == pri_pkg::IDX_CTRL_UNEQ_TRACE)
                ctrl_uneq_trace_q <= w_byte_q;
            if (aw_idx_q == pri_pkg::IDX_CTRL_POINTER_AIS)
                ctrl_pointer_ais_q <= w_byte_q;
        end
    end

    // Read path
    // Status is read only; writes to it answer OKAY and change nothing
    assign ar_idx = s_axi_araddr[pri_pkg::ADDR_W-1:pri_pkg::IDX_LSB];
    assign defects = {def_label_mismatch, def_cell_delineation,
        def_trace_mismatch, def_unequipped, def_pointer_loss,
        def_path_alarm};

    always_comb
    begin
        rd_value = '0;
        rd_hit = 1'b1;
        unique case (ar_idx)
            pri_pkg::IDX_PATH_CTRL:
                rd_value[7:0] = path_ctrl_q;
            pri_pkg::IDX_CTRL_CELL_LABEL:
                rd_value[7:0] = ctrl_cell_label_q;
            pri_pkg::IDX_CTRL_UNEQ_TRACE:
                rd_value[7:0] = ctrl_uneq_trace_q;
            pri_pkg::IDX_CTRL_POINTER_AIS:
                rd_value[7:0] = ctrl_pointer_ais_q;
            pri_pkg::IDX_STATUS:
                rd_value[8:0] = {rdi_code_q, defects};
            default:
                rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= pri_pkg::RESP_OKAY;
            rdata_q <= '0;
        end
        else if (s_axi_arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_value;
            rresp_q <= rd_hit ? pri_pkg::RESP_OKAY : pri_pkg::RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
        else if (!rvalid_q)
            arready_q <= 1'b1;
    end

    // Priority: alarm, pointer, unequipped, trace, label, cell delineation
    // Fixed order so several defects at once never flip the code
    always_comb
    begin
        rdi_code_d = pri_pkg::RDI_NONE;
        if (def_path_alarm && ctrl_pointer_ais_q[pri_pkg::LO_EN_BIT])
            rdi_code_d = ctrl_pointer_ais_q[pri_pkg::LO_CODE_MSB:
                pri_pkg::LO_CODE_LSB];
        else if (def_pointer_loss
            && ctrl_pointer_ais_q[pri_pkg::HI_EN_BIT])
            rdi_code_d = ctrl_pointer_ais_q[pri_pkg::HI_CODE_MSB:
                pri_pkg::HI_CODE_LSB];
        else if (def_unequipped && ctrl_uneq_trace_q[pri_pkg::LO_EN_BIT])
            rdi_code_d = ctrl_uneq_trace_q[pri_pkg::LO_CODE_MSB:
                pri_pkg::LO_CODE_LSB];
        else if (def_trace_mismatch
            && ctrl_uneq_trace_q[pri_pkg::HI_EN_BIT])
            rdi_code_d = ctrl_uneq_trace_q[pri_pkg::HI_CODE_MSB:
                pri_pkg::HI_CODE_LSB];
        else if (def_label_mismatch
            && ctrl_cell_label_q[pri_pkg::LO_EN_BIT])
            rdi_code_d = ctrl_cell_label_q[pri_pkg::LO_CODE_MSB:
                pri_pkg::LO_CODE_LSB];
        else if (def_cell_delineation
            && ctrl_cell_label_q[pri_pkg::HI_EN_BIT])
            rdi_code_d = ctrl_cell_label_q[pri_pkg::HI_CODE_MSB:
                pri_pkg::HI_CODE_LSB];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            rdi_code_q <= pri_pkg::RDI_NONE;
        else
            rdi_code_q <= rdi_code_d;
    end

    // Other source modes are handled elsewhere; G1 then passes untouched
    // Code is one cycle old at insertion; defects last far longer
    assign auto_mode = path_ctrl_q[pri_pkg::SRC_SEL_MSB:pri_pkg::SRC_SEL_LSB]
        == pri_pkg::SRC_SEL_AUTO;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            tx_byte_out_q <= 8'h00;
            tx_g1_slot_out_q <= 1'b0;
        end
        else
        begin
            tx_byte_out_q <= tx_byte_in;
            tx_g1_slot_out_q <= tx_g1_slot;
            if (tx_g1_slot && auto_mode)
                tx_byte_out_q[pri_pkg::G1_RDI_MSB:pri_pkg::G1_RDI_LSB]
                    <= rdi_code_q;
        end
    end

endmodule

// ==== sim/pri_rdi_chk.sv ====
`timescale 1ns/1ns
module pri_rdi_chk (
    input logic clk_sys, // Clock
    input logic rst_n, // Reset, active low
    input logic def_unequipped, // Defect
    input logic def_pointer_loss, // Defect
    input logic def_path_alarm, // Defect
    input logic def_trace_mismatch, // Defect
    input logic def_cell_delineation, // Defect
    input logic def_label_mismatch, // Defect
    input logic [7:0] tx_byte_in, // Byte in
    input logic tx_g1_slot, // G1 marker in
    input logic [7:0] tx_byte_out_q, // Byte out
    input logic tx_g1_slot_out_q, // G1 marker out
    input logic [2:0] rdi_code_q, // Selected code
    input logic s_axi_awvalid, // Bus
    input logic s_axi_awready, // Bus
    input logic s_axi_wvalid, // Bus
    input logic s_axi_wready, // Bus
    input logic [1:0] s_axi_bresp, // Bus
    input logic s_axi_bvalid, // Bus
    input logic s_axi_bready, // Bus
    input logic s_axi_arvalid, // Bus
    input logic s_axi_arready, // Bus
    input logic [31:0] s_axi_rdata, // Bus
    input logic s_axi_rvalid, // Bus
    input logic s_axi_rready // Bus
);
    logic any_def;
    assign any_def = def_unequipped | def_pointer_loss | def_path_alarm
        | def_trace_mismatch | def_cell_delineation | def_label_mismatch;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_idle_code_zero: assert property (!any_def |=> rdi_code_q == 3'h0)
        else $error("code set with no defect");
    a_plain_pass: assert property (rst_n && !tx_g1_slot |=>
        tx_byte_out_q == $past(tx_byte_in)) else $error("byte altered");
    a_g1_keep_bits: assert property (rst_n && tx_g1_slot |=>
        tx_byte_out_q[7:4] == $past(tx_byte_in[7:4])
        && tx_byte_out_q[0] == $past(tx_byte_in[0]))
        else $error("G1 outer bits altered");
    a_g1_code_put: assert property (tx_g1_slot_out_q
        && tx_byte_out_q[3:1] != $past(tx_byte_in[3:1])
        |-> tx_byte_out_q[3:1] == $past(rdi_code_q))
        else $error("G1 bits not the code");
    a_mark_follow: assert property (tx_g1_slot |=> tx_g1_slot_out_q)
        else $error("G1 marker lost");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("no write response");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("no read data");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    c_code_sent: cover property (tx_g1_slot_out_q && rdi_code_q != 3'h0);
    c_write_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind pri_path_rdi_auto_insertion pri_rdi_chk pri_rdi_chk_i (.clk_sys,
    .rst_n, .def_unequipped, .def_pointer_loss, .def_path_alarm,
    .def_trace_mismatch, .def_cell_delineation, .def_label_mismatch,
    .tx_byte_in, .tx_g1_slot, .tx_byte_out_q, .tx_g1_slot_out_q,
    .rdi_code_q, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready);

// ==== sim/pri_far_end.sv ====
`timescale 1ns/1ns
module pri_far_end (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic [7:0] rx_byte, // Byte from framer
    input wire logic rx_g1_slot, // G1 marker
    output logic [2:0] g1_rdi_q // Last defect bits seen
);
    // Line bits 5..7 sit in byte bits 3..1
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            g1_rdi_q <= 3'h0;
        else if (rx_g1_slot)
            g1_rdi_q <= rx_byte[3:1];
    end
endmodule

// ==== sim/pri_path_rdi_auto_insertion_test.sv ====
`timescale 1ns/1ns
module pri_path_rdi_auto_insertion_test;
    localparam logic [15:0] AP = {pri_pkg::IDX_PATH_CTRL, 2'h0};
    localparam logic [15:0] A0 = {pri_pkg::IDX_CTRL_POINTER_AIS, 2'h0};
    localparam logic [15:0] A1 = {pri_pkg::IDX_CTRL_UNEQ_TRACE, 2'h0};
    localparam logic [15:0] A2 = {pri_pkg::IDX_CTRL_CELL_LABEL, 2'h0};
    logic clk_sys = 1'h0, rst_n = 1'h0, tx_g1_slot = 1'h0;
    logic [7:0] tx_byte_in = 8'h3c, v;
    logic [5:0] def_v = 6'h00, hi = 6'h1a;
    logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
    logic [31:0] s_axi_wdata = 32'h0, d;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, tx_g1_slot_out_q;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata;
    logic [7:0] tx_byte_out_q;
    logic [2:0] rdi_code_q, g1_rdi, c;
    logic [15:0] adr [6] = '{A0, A0, A1, A1, A2, A2};
    logic [5:0] pm [6] = '{6'h3f, 6'h3e, 6'h3c, 6'h38, 6'h30, 6'h10};
    int n_errors = 0, comparisons = 0, cyc = 0;
    pri_path_rdi_auto_insertion pri_path_rdi_auto_insertion_i (.clk_sys,
        .rst_n, .def_path_alarm(def_v[0]), .def_pointer_loss(def_v[1]),
        .def_unequipped(def_v[2]), .def_trace_mismatch(def_v[3]),
        .def_cell_delineation(def_v[4]), .def_label_mismatch(def_v[5]),
        .tx_byte_in, .tx_g1_slot, .tx_byte_out_q, .tx_g1_slot_out_q,
        .rdi_code_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    pri_far_end pri_far_end_i (.clk_sys, .rst_n, .rx_byte(tx_byte_out_q),
        .rx_g1_slot(tx_g1_slot_out_q), .g1_rdi_q(g1_rdi));
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    // Ready raised late on purpose so responses must hold
    task automatic wr(input logic [15:0] a, input logic [7:0] x);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, x};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        @(posedge clk_sys);
        while (!(s_axi_bvalid && s_axi_bready))
        begin
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid)
                s_axi_bready <= 1'h1;
            @(posedge clk_sys);
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        @(posedge clk_sys);
        while (!(s_axi_rvalid && s_axi_rready))
        begin
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
                s_axi_rready <= 1'h1;
            @(posedge clk_sys);
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic g1(input logic [5:0] dv, input logic [7:0] eb, input au);
        @(posedge clk_sys);
        def_v <= dv;
        @(posedge clk_sys);
        tx_byte_in <= 8'ha5;
        tx_g1_slot <= 1'h1;
        @(posedge clk_sys);
        tx_byte_in <= 8'h3c;
        tx_g1_slot <= 1'h0;
        @(negedge clk_sys);
        chk("g1 byte", eb, tx_byte_out_q);
        chk("g1 marker", 32'h1, tx_g1_slot_out_q);
        if (au)
            chk("rdi code", eb[3:1], rdi_code_q);
        @(negedge clk_sys);
        chk("far end bits", eb[3:1], g1_rdi);
    endtask
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'h1;
        rd(AP);
        chk("path ctrl reset", 32'h01, d);
        for (int i = 0; i < 6; i += 2)
        begin
            rd(adr[i]);
            chk("ctrl reset", 32'h0, d);
        end
        wr(AP, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            c = 3'(7 - i);
            v = hi[i] ? {c, 5'h10} : {4'h0, c, 1'h1};
            wr(adr[i], v);
            chk("bresp", pri_pkg::RESP_OKAY, r);
            rd(adr[i]);
            chk("ctrl readback", {24'h0, v}, d);
            chk("rresp", pri_pkg::RESP_OKAY, r);
            g1(6'(1 << i), {4'ha, c, 1'h1}, 1'h1);
            wr(adr[i], v & (hi[i] ? 8'hef : 8'hfe));
            g1(6'(1 << i), 8'ha1, 1'h1);
        end
        wr(A0, 8'h53);
        wr(A1, 8'h97);
        wr(A2, 8'hdb);
        for (int k = 0; k < 6; k++)
            g1(pm[k], {4'ha, 3'(k + 1), 1'h1}, 1'h1);
        rd({pri_pkg::IDX_STATUS, 2'h0});
        chk("status", 32'h190, d);
        g1(6'h00, 8'ha1, 1'h1);
        wr(AP, 8'h08);
        g1(6'h3f, 8'ha5, 1'h0);
        wr(16'h0000, 8'hff);
        chk("unmapped bresp", pri_pkg::RESP_SLVERR, r);
        rd(16'h0000);
        chk("unmapped rresp", pri_pkg::RESP_SLVERR, r);
        chk("unmapped rdata", 32'h0, d);
        print_verdict();
    end
endmodule
